// File: i2c_gpio_expander_eeprom.sv
// Two-wire slave with an 8-pin quasi-bidirectional port and page memory.
// Assumes bus, straps and pins are asynchronous and come through pads.
//
// Notes on behaviour
// - Address bit 0 high reads, low writes
// - Three select straps join address match
// - Port and memory answer separate addresses
// - One control byte, written only; a read returns pin levels
// - Port write drives pins, read returns levels
// - Reset leaves every pin weakly high
// - Strong pull-up until next clock fall
// - Memory write carries 8-bit word address
// - Protect input high blocks array changes
// - Byte write: acknowledge address, word, data
// - STOP after memory write starts programming
// - Memory ignored while programming; port served
// - Page data increments two low bits
// - Fifth data byte wraps, overwrites page
// - Works from static to fast clock rate
// - Counter points past last accessed word
// - Random read: dummy write, restart, read
// - Sequential read wraps top to zero
`timescale 1ns/1ns
`default_nettype none
module i2c_gpio_expander_eeprom
  import i2c_exp_pkg::*;
#(
  parameter logic [3:0] PORT_ADDR_HI_P = PORT_ADDR_HI,
  parameter logic [3:0] MEM_ADDR_HI_P = MEM_ADDR_HI,
  parameter int PROG_CYCLES_P = PROG_CYCLES,
  parameter bit ACK_WHEN_PROTECTED = 1'b1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps
  input wire logic addr_sel_0,
  input wire logic addr_sel_1,
  input wire logic addr_sel_2,
  input wire logic write_protect_n,
  // Port pins
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_pin_out,
  output logic [7:0] port_pin_oe,
  // Status
  output logic prog_busy
);

  // ----------------------------------------------------------------
  // Synchronisers and bus events
  // ----------------------------------------------------------------
  logic [13:0] raw_in;
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl, sda, wp_n;
  logic [2:0] sel;
  logic [7:0] pins;
  logic scl_rise, scl_fall, start_evt, stop_evt;

  assign raw_in = {port_pin_in, write_protect_n, addr_sel_2, addr_sel_1,
                   addr_sel_0, sda_in, scl_in};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 14'h3FFF;
      sync2_reg <= 14'h3FFF;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (clk_en) begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[0];
      sda_d_reg <= sync2_reg[1];
    end
  end

  assign scl = sync2_reg[0];
  assign sda = sync2_reg[1];
  assign sel = sync2_reg[4:2];
  assign wp_n = sync2_reg[5];
  assign pins = sync2_reg[13:6];

  // Edge finding on the sampled clock; 100 ns sampling leaves margin
  // at the fastest bus rate and has no lower limit
  assign scl_rise = clk_en & scl & ~scl_d_reg;
  assign scl_fall = clk_en & ~scl & scl_d_reg;
  assign start_evt = clk_en & scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop_evt = clk_en & scl & scl_d_reg & ~sda_d_reg & sda;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  bus_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [1:0] byte_idx_reg, byte_idx_next;
  logic mem_sel_reg, mem_sel_next;
  logic rw_reg, rw_next;
  logic sda_oe_reg, sda_oe_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] pullup_reg, pullup_next;
  logic [7:0] pin_oe_reg, pin_oe_next;
  logic [7:0] addr_cnt_reg, addr_cnt_next;
  logic [31:0] page_data_reg, page_data_next;
  logic [3:0] page_vld_reg, page_vld_next;
  logic busy_reg, busy_next;
  logic byte_done, port_hit, mem_hit, load_now, ack_now, prog_go;
  logic port_wr, mem_data, wr_allowed, pg_clear;
  logic [7:0] tx_byte;
  logic [7:0] mem_rdata;

  assign byte_done = (state_reg == ST_RX) & scl_fall &
                     (bit_cnt_reg == BITS_BYTE);
  assign port_hit = byte_done & (byte_idx_reg == IDX_ADDR) &
                    (shift_reg[7:1] == {PORT_ADDR_HI_P, sel});
  assign mem_hit = byte_done & (byte_idx_reg == IDX_ADDR) & ~busy_reg &
                   (shift_reg[7:1] == {MEM_ADDR_HI_P, sel});
  assign port_wr = byte_done & (byte_idx_reg != IDX_ADDR) & ~mem_sel_reg;
  assign mem_data = byte_done & (byte_idx_reg == IDX_DATA) & mem_sel_reg;
  assign wr_allowed = ~wp_n;
  assign load_now = scl_fall & (((state_reg == ST_ACK) & rw_reg) |
                    ((state_reg == ST_MACK) & (bit_cnt_reg == BITS_MACK)));
  assign tx_byte = mem_sel_reg ? mem_rdata : pins;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    byte_idx_next = byte_idx_reg;
    mem_sel_next = mem_sel_reg;
    rw_next = rw_reg;
    sda_oe_next = sda_oe_reg;
    ctrl_next = ctrl_reg;
    pullup_next = scl_fall ? 8'h00 : pullup_reg;
    addr_cnt_next = addr_cnt_reg;
    page_data_next = page_data_reg;
    page_vld_next = pg_clear ? 4'h0 : page_vld_reg;
    ack_now = 1'b0;
    prog_go = 1'b0;
    case (state_reg)
      ST_RX: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (byte_done) begin
          if (byte_idx_reg == IDX_ADDR) begin
            ack_now = port_hit | mem_hit;
            mem_sel_next = mem_hit;
            rw_next = shift_reg[0];
          end else if (!mem_sel_reg) begin
            ack_now = 1'b1;
            ctrl_next = shift_reg;
            pullup_next = shift_reg;
          end else if (byte_idx_reg == IDX_WORD) begin
            ack_now = 1'b1;
            addr_cnt_next = shift_reg;
          end else begin
            ack_now = wr_allowed | ACK_WHEN_PROTECTED;
            if (wr_allowed) begin
              page_data_next[{addr_cnt_reg[1:0], 3'h0} +: 8] = shift_reg;
              page_vld_next[addr_cnt_reg[1:0]] = 1'b1;
            end
            addr_cnt_next[1:0] = addr_cnt_reg[1:0] + 2'h1;
          end
          if (byte_idx_reg != IDX_DATA) begin
            byte_idx_next = byte_idx_reg + 2'h1;
          end
          state_next = ack_now ? ST_ACK : ST_IDLE;
          sda_oe_next = ack_now;
        end
      end
      ST_ACK: begin
        if (scl_fall && !rw_reg) begin
          sda_oe_next = 1'b0;
          bit_cnt_next = 4'h0;
          state_next = ST_RX;
        end
      end
      ST_TX: begin
        if (scl_rise) begin
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (scl_fall) begin
          if (bit_cnt_reg == BITS_BYTE) begin
            sda_oe_next = 1'b0;
            bit_cnt_next = 4'h0;
            state_next = ST_MACK;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            sda_oe_next = ~shift_reg[6];
          end
        end
      end
      ST_MACK: begin
        // Master's missing acknowledge ends the read
        if (scl_rise) begin
          if (sda) begin
            state_next = ST_IDLE;
          end else begin
            bit_cnt_next = BITS_MACK;
          end
        end
      end
      ST_IDLE: begin
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (load_now) begin
      shift_next = tx_byte;
      sda_oe_next = ~tx_byte[7];
      bit_cnt_next = 4'h0;
      state_next = ST_TX;
      if (mem_sel_reg) begin
        addr_cnt_next = addr_cnt_reg + 8'h01;
      end
    end
    if (start_evt) begin
      state_next = ST_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = IDX_ADDR;
      sda_oe_next = 1'b0;
    end else if (stop_evt) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      prog_go = mem_sel_reg & ~rw_reg & (|page_vld_reg) & ~busy_reg;
    end
    pin_oe_next = ~ctrl_next | pullup_next;
  end

  // Control byte resets to all ones: pins weakly high, usable as inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= IDX_ADDR;
      mem_sel_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      sda_out <= 1'b0;
      ctrl_reg <= PORT_CTRL_RESET;
      pullup_reg <= 8'h00;
      pin_oe_reg <= 8'h00;
      addr_cnt_reg <= 8'h00;
      page_data_reg <= 32'h0000_0000;
      page_vld_reg <= 4'h0;
    end else if (clk_en) begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      byte_idx_reg <= byte_idx_next;
      mem_sel_reg <= mem_sel_next;
      rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next;
      sda_out <= 1'b0;
      ctrl_reg <= ctrl_next;
      pullup_reg <= pullup_next;
      pin_oe_reg <= pin_oe_next;
      addr_cnt_reg <= addr_cnt_next;
      page_data_reg <= page_data_next;
      page_vld_reg <= page_vld_next;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign port_pin_out = ctrl_reg;
  assign port_pin_oe = pin_oe_reg;

  // ----------------------------------------------------------------
  // Self-timed programming
  // ----------------------------------------------------------------
  prog_state_type pg_state_reg, pg_state_next;
  logic [1:0] pg_idx_reg, pg_idx_next;
  logic [23:0] pg_cnt_reg, pg_cnt_next;
  logic mem_we;
  logic [7:0] mem_waddr, mem_wdata;

  always_comb begin
    pg_state_next = pg_state_reg;
    pg_idx_next = pg_idx_reg;
    pg_cnt_next = pg_cnt_reg;
    pg_clear = 1'b0;
    mem_we = 1'b0;
    mem_waddr = {addr_cnt_reg[7:2], pg_idx_reg};
    mem_wdata = page_data_reg[{pg_idx_reg, 3'h0} +: 8];
    case (pg_state_reg)
      PG_IDLE: begin
        if (prog_go) begin
          pg_state_next = PG_WRITE;
          pg_idx_next = 2'h0;
        end
      end
      PG_WRITE: begin
        mem_we = clk_en & page_vld_reg[pg_idx_reg];
        pg_idx_next = pg_idx_reg + 2'h1;
        if (pg_idx_reg == 2'h3) begin
          pg_clear = clk_en;
          pg_state_next = PG_WAIT;
          pg_cnt_next = 24'(PROG_CYCLES_P - 1);
        end
      end
      PG_WAIT: begin
        if (pg_cnt_reg == 24'h00_0000) begin
          pg_state_next = PG_IDLE;
        end else begin
          pg_cnt_next = pg_cnt_reg - 24'h00_0001;
        end
      end
      default: begin
        pg_state_next = PG_IDLE;
      end
    endcase
    busy_next = (pg_state_next != PG_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pg_state_reg <= PG_IDLE;
      pg_idx_reg <= 2'h0;
      pg_cnt_reg <= 24'h00_0000;
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      pg_state_reg <= pg_state_next;
      pg_idx_reg <= pg_idx_next;
      pg_cnt_reg <= pg_cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign prog_busy = busy_reg;

  i2c_exp_mem u_mem (
    .clk(clk),
    .clk_en(clk_en),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(addr_cnt_reg),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_dir_read_tx: assert property (
    load_now && !start_evt |=> state_reg == ST_TX)
    else $error("read direction did not start transmit");
  a_port_addr_ack: assert property (
    port_hit && !start_evt && !stop_evt |=> state_reg == ST_ACK && sda_oe)
    else $error("port address not acknowledged");
  a_busy_mem_nack: assert property (
    byte_done && busy_reg && byte_idx_reg == IDX_ADDR && !port_hit
    && !start_evt |=> state_reg == ST_IDLE && !sda_oe)
    else $error("memory answered while programming");
  a_ctrl_write: assert property (
    port_wr && !start_evt |=> port_pin_out == $past(shift_reg))
    else $error("control byte not written");
  a_pullup_drop: assert property (
    scl_fall && !port_wr |=> port_pin_oe == ~port_pin_out)
    else $error("strong pull-up still on after clock fall");
  a_protect_hold: assert property (
    mem_data && wp_n |=> $stable(page_vld_reg))
    else $error("protected byte latched");
  a_page_wrap: assert property (
    mem_data && !start_evt |=> addr_cnt_reg[7:2] == $past(addr_cnt_reg[7:2])
    && addr_cnt_reg[1:0] == $past(addr_cnt_reg[1:0]) + 2'h1)
    else $error("page address step wrong");
  a_stop_prog: assert property (
    prog_go && clk_en |=> prog_busy && pg_state_reg == PG_WRITE)
    else $error("stop did not start programming");
  a_read_incr: assert property (
    load_now && mem_sel_reg |=> addr_cnt_reg == $past(addr_cnt_reg) + 8'h01)
    else $error("address counter did not advance");
  a_word_addr: assert property (
    byte_done && mem_sel_reg && byte_idx_reg == IDX_WORD && !start_evt
    |=> addr_cnt_reg == $past(shift_reg) && sda_oe)
    else $error("word address not taken");

  c_port_write: cover property (port_wr ##[1:300] state_reg == ST_RX);
  c_mem_read: cover property (load_now && mem_sel_reg);
  c_prog_cycle: cover property (prog_go ##[1:8] pg_state_reg == PG_WAIT);
  c_read_nack: cover property (state_reg == ST_MACK && scl_rise && sda);

endmodule : i2c_gpio_expander_eeprom
`default_nettype wire

// File: i2c_exp_pkg.sv
// Constants and types shared by the port expander with page memory.
// Assumes a single 10 MHz system clock; the serial bus is sampled on it.
package i2c_exp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = PROG_TIME_US * (CLK_FREQ_KHZ / 1000);

  // ----------------------------------------------------------------
  // Addressing and layout
  // ----------------------------------------------------------------
  // Fixed upper address bits; values are arbitrary
  localparam logic [3:0] PORT_ADDR_HI = 4'h2;
  localparam logic [3:0] MEM_ADDR_HI = 4'h5;
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BYTES = 4;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_WORD = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_MACK = 4'h9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_CTRL_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} bus_state_type;
  typedef enum {PG_IDLE, PG_WRITE, PG_WAIT} prog_state_type;

endpackage : i2c_exp_pkg

// File: i2c_exp_mem.sv
// 256 by 8 storage array with one write port and a registered read.
// Assumes writes and reads on the same clock; contents have no reset.
`timescale 1ns/1ns
`default_nettype none
module i2c_exp_mem
  import i2c_exp_pkg::*;
(
  // Clock
  input wire logic clk,
  input wire logic clk_en,
  // Write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem_array [MEM_WORDS];

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  // Non-volatile contents, so no reset
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (we) begin
        mem_array[waddr] <= wdata;
      end
      rdata <= mem_array[raddr];
    end
  end

endmodule : i2c_exp_mem
`default_nettype wire

// File: i2c_master_model.sv
// Two-wire bus master model: drives SCL and the master's share of SDA.
// Assumes pull-ups on both lines, so a released SDA reads as one.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_line,
  output var logic scl,
  output var logic sda_drv
);
  // Quarter bit in clocks; each SCL phase lasts 8 clocks, above the
  // 6-clock minimum, and SDA moves 4 clocks after SCL falls
  localparam int QTR = 4;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic qwait(input int n);
    repeat (n * QTR) @(negedge clk);
  endtask : qwait

  // Also serves as repeated start when SCL is low
  task automatic start();
    if (!scl) begin
      qwait(1);
      sda_drv = 1'b1;
      qwait(1);
      scl = 1'b1;
    end
    qwait(2);
    sda_drv = 1'b0;
    qwait(2);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    qwait(1);
    sda_drv = 1'b0;
    qwait(1);
    scl = 1'b1;
    qwait(2);
    sda_drv = 1'b1;
    qwait(2);
  endtask : stop

  // Line sampled at the end of the high phase
  task automatic bit_xfer(input logic b, output logic s);
    qwait(1);
    sda_drv = b;
    qwait(1);
    scl = 1'b1;
    qwait(2);
    s = sda_line;
    scl = 1'b0;
  endtask : bit_xfer

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = !s;
  endtask : write_byte

  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(!mack, s);
  endtask : read_byte
endmodule : i2c_master_model
`default_nettype wire

// File: i2c_gpio_expander_eeprom_tb.sv
// Self-checking bench for the port expander with page memory.
// Assumes the master model file; pins get weak pull-ups modelled here.
`timescale 1ns/1ns
`default_nettype none
module i2c_gpio_expander_eeprom_tb
  import i2c_exp_pkg::*;
;
  logic clk, rst, scl, sda_drv, sda_oe, sda_out, wp_n, prog_busy;
  logic [2:0] sel;
  logic [7:0] ext_low, pin_out, pin_oe;
  wire logic sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
  wire logic [7:0] pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
  int fails = 0;
  int n_checks = 0;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  // Long programming count keeps busy up across a few bus frames
  i2c_gpio_expander_eeprom #(.PROG_CYCLES_P(2000)) dut_u (
    .clk(clk), .rst(rst), .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel_0(sel[0]), .addr_sel_1(sel[1]), .addr_sel_2(sel[2]),
    .write_protect_n(wp_n), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe(pin_oe),
    .prog_busy(prog_busy));
  i2c_master_model mst_u (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] sla(input logic mem, input logic rd);
    return {mem ? MEM_ADDR_HI : PORT_ADDR_HI, sel, rd};
  endfunction : sla

  task automatic tx(input logic [7:0] d, input logic ea);
    logic a;
    mst_u.write_byte(d, a);
    check({7'h00, a}, {7'h00, ea});
  endtask : tx

  task automatic rx(input logic mack, input logic [7:0] e);
    logic [7:0] d;
    mst_u.read_byte(mack, d);
    check(d, e);
  endtask : rx

  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && prog_busy !== 1'b0; i++) @(negedge clk);
    if (i == 3000) begin
      fails++;
      print_verdict();
    end
  endtask : wait_idle

  // First data byte in the top bits of d; eb is the busy level checked after STOP
  task automatic mem_write(input logic [7:0] w, input int n,
    input logic [39:0] d, input logic eb);
    mst_u.start();
    tx(sla(1'b1, 1'b0), 1'b1);
    tx(w, 1'b1);
    for (int i = 0; i < n; i++) tx(d[39-8*i -: 8], 1'b1);
    mst_u.stop();
    check({7'h00, prog_busy}, {7'h00, eb});
  endtask : mem_write

  task automatic mem_read(input logic [7:0] w, input int n,
    input logic [31:0] e);
    mst_u.start();
    tx(sla(1'b1, 1'b0), 1'b1);
    tx(w, 1'b1);
    mst_u.start();
    tx(sla(1'b1, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) rx(i < n - 1, e[31-8*i -: 8]);
    mst_u.stop();
  endtask : mem_read

  task automatic port_write(input logic [7:0] v);
    mst_u.start();
    tx(sla(1'b0, 1'b0), 1'b1);
    tx(v, 1'b1);
    check(pin_oe, 8'hFF);
    check(pin_out, v);
    mst_u.stop();
    check(pin_oe, ~v);
  endtask : port_write

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(pin_out, 8'hFF);
    check(pin_oe, 8'h00);
    check({6'h00, sda_oe, prog_busy}, 8'h00);
  endtask : t_reset

  task automatic t_port();
    port_write(8'h5A);
    port_write(8'hFF);
    ext_low = 8'h3C;
    mst_u.start();
    tx(sla(1'b0, 1'b1), 1'b1);
    rx(1'b0, 8'hC3);
    mst_u.stop();
    ext_low = 8'h00;
    mst_u.start();
    tx({PORT_ADDR_HI, ~sel, 1'b0}, 1'b0);
    mst_u.stop();
  endtask : t_port

  task automatic t_page();
    mem_write(8'h12, 5, 40'hA1B2C3D4E5, 1'b1);
    mst_u.start();
    tx(sla(1'b1, 1'b1), 1'b0);
    mst_u.stop();
    mst_u.start();
    tx(sla(1'b0, 1'b1), 1'b1);
    rx(1'b0, 8'hFF);
    mst_u.stop();
    wait_idle();
    mem_read(8'h10, 4, 32'hC3D4E5B2);
  endtask : t_page

  task automatic t_protect();
    wp_n = 1'b1;
    mem_write(8'h13, 1, 40'hEE00000000, 1'b0);
    wp_n = 1'b0;
    mem_read(8'h13, 1, 32'hB2000000);
  endtask : t_protect

  task automatic t_wrap();
    mem_write(8'hFF, 1, 40'h3C00000000, 1'b1);
    wait_idle();
    mem_write(8'h00, 1, 40'hC300000000, 1'b1);
    wait_idle();
    mem_read(8'hFF, 1, 32'h3C000000);
    mst_u.start();
    tx(sla(1'b1, 1'b1), 1'b1);
    rx(1'b0, 8'hC3);
    mst_u.stop();
  endtask : t_wrap

  initial begin
    rst = 1'b1;
    sel = 3'b101;
    wp_n = 1'b0;
    ext_low = 8'h00;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_port();
    t_page();
    t_protect();
    t_wrap();
    print_verdict();
  end
endmodule : i2c_gpio_expander_eeprom_tb
`default_nettype wire
